//--- verilog/pcm_top.sv
////////////////////////////////////////////////////////////////////////////////
// How it works
// [RQ1] Outside party drives oscillator input with a clock or fits a crystal there.
// [RQ2] Oscillator output only drives the crystal, never used in external clock mode.
// [RQ3] System clock is presented on the system clock output pin.
// [RQ4] Mode select pins are held outside and sampled at configuration.
// [RQ5] Reset output pin low during system reset or while force bit set.
// [RQ6] Control at 0x120000, status at 0x120002, supervisor access only.
// [RQ7] Control bit 15 set makes a lock loss request a system reset.
// [RQ8] Setting the enable while unlocked in PLL modes requests reset at once.
// [RQ9] Software clears the enable before retuning or stopping the PLL.
// [RQ10] External clock mode ignores the lock loss reset enable.
// [RQ11] Control bits 14 to 12 hold the feedback multiplier.
// [RQ12] Changing the multiplier or stopping the PLL drops lock.
// [RQ13] In 1:1 mode the multiplier field is ignored, factor is one.
// [RQ14] In external clock mode multiplier writes leave clocking alone.
// [RQ15] Three modes: normal PLL by default, 1:1 PLL and external clock.
// [RQ16] External clock mode bypasses the PLL and follows the input clock.
// [RQ17] Lock drop with enable set sends a reset request to the controller.
module pcm_top
  import pcm_pkg::*;
#(
  parameter int LOCK_CNT = LOCK_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              osc_in_i,
  output logic                   osc_out_o,
  output logic                   sys_clk_o,
  input  wire logic [1:0]        clock_mode_select_i,
  output logic                   reset_out_n_o,
  input  wire logic              stop_i,
  input  wire logic              stop_pll_off_i,
  input  wire logic              supervisor_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   irq_o,
  output logic                   lock_reset_req_o
);
  ////////////////////////////////////////////////////////////////////////////
  pcm_lock_if lk ();

  pcm_lock #(
    .LOCK_CNT (LOCK_CNT)
  ) u_lock (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .lk      (lk)
  );

  ////////////////////////////////////////////////////////////////////////////
  pcm_mode_type      mode;
  pcm_mode_type      next_mode;
  logic              cfg_done;
  logic              next_cfg_done;
  logic              lock_loss_reset_enable;
  logic              next_lock_loss_reset_enable;
  logic [MFD_W-1:0]  feedback_multiplier_field;
  logic [MFD_W-1:0]  next_mfd;
  logic              force_rst;
  logic              next_force_rst;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  next_irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  next_irq_mask;
  logic              locked_q;
  logic [4:0]        div_cnt;
  logic [4:0]        next_div_cnt;
  logic              next_sys_clk;
  logic              next_osc_out;
  logic              next_reset_out_n;
  logic              next_irq;
  logic              next_req;
  logic [DATA_W-1:0] next_rdata;
  logic [4:0]        eff_mult;
  logic              pll_on;
  logic              relock;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode; user mode sees nothing and changes nothing
  logic wr_ok;
  logic rd_ok;
  logic wr_ctrl;
  logic wr_rstc;
  logic wr_istat;
  logic wr_imask;
  logic lost_ev;
  logic gain_ev;

  assign wr_ok    = wr_i && supervisor_i;  // [RQ6]
  assign rd_ok    = rd_i && supervisor_i;  // [RQ6]
  assign wr_ctrl  = wr_ok && (addr_i == SYNTH_CONTROL_ADDR);  // [RQ6]
  assign wr_rstc  = wr_ok && (addr_i == RESET_CTRL_ADDR);
  assign wr_istat = wr_ok && (addr_i == IRQ_STATUS_ADDR);
  assign wr_imask = wr_ok && (addr_i == IRQ_MASK_ADDR);
  assign lost_ev  = locked_q && !lk.locked;
  assign gain_ev  = !locked_q && lk.locked;

  // External mode has no PLL at all, so no lock timer runs there
  assign pll_on = cfg_done && (mode != PCM_MODE_EXT)
                  && !(stop_i && stop_pll_off_i);  // [RQ12] [RQ16]
  // Only normal mode retunes; the field is dead in 1:1 and external
  assign relock = wr_ctrl && (mode == PCM_MODE_NORMAL)
                  && (wdata_i[MFD_HI:MFD_LO] != feedback_multiplier_field);  // [RQ12] [RQ13] [RQ14]
  assign lk.pll_on = pll_on;
  assign lk.relock = relock;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_mode        = mode;
    next_cfg_done    = 1'b1;
    next_lock_loss_reset_enable       = lock_loss_reset_enable;
    next_mfd         = feedback_multiplier_field;
    next_force_rst   = force_rst;
    next_irq_mask    = irq_mask;
    next_irq_status  = irq_status;
    next_rdata       = '0;
    next_req         = 1'b0;
    eff_mult         = MULT_ONE;
    // Straps are caught once, in the first cycle after reset release
    if (!cfg_done) begin
      unique case (clock_mode_select_i)  // [RQ4] [RQ15]
        MODE_SEL_EXT: next_mode = PCM_MODE_EXT;
        MODE_SEL_ONE: next_mode = PCM_MODE_ONE;
        default:      next_mode = PCM_MODE_NORMAL;
      endcase
    end
    if (wr_ctrl) begin
      next_lock_loss_reset_enable = wdata_i[LOCK_LOSS_RESET_ENABLE_BIT];  // [RQ7]
      next_mfd   = wdata_i[MFD_HI:MFD_LO];  // [RQ11]
    end
    if (wr_rstc) begin
      next_force_rst = wdata_i[FORCE_RST_BIT];
    end
    if (wr_imask) begin
      next_irq_mask = wdata_i[IRQ_W-1:0];
    end
    // Write one to clear, but a new event in the same cycle wins
    if (wr_istat) begin
      next_irq_status = irq_status & ~wdata_i[IRQ_W-1:0];
    end
    next_irq_status[IRQ_LOST_BIT]   = next_irq_status[IRQ_LOST_BIT] | lost_ev;
    next_irq_status[IRQ_GAINED_BIT] = next_irq_status[IRQ_GAINED_BIT] | gain_ev;
    // Loss with the enable set, or enable set while unlocked
    if (mode != PCM_MODE_EXT) begin  // [RQ10]
      next_req = (lock_loss_reset_enable && lost_ev)  // [RQ7] [RQ17]
                 || (wr_ctrl && wdata_i[LOCK_LOSS_RESET_ENABLE_BIT] && !lk.locked);  // [RQ8]
    end
    if (rd_ok) begin
      unique case (addr_i)
        SYNTH_CONTROL_ADDR: begin
          next_rdata[LOCK_LOSS_RESET_ENABLE_BIT]     = lock_loss_reset_enable;
          next_rdata[MFD_HI:MFD_LO] = feedback_multiplier_field;
        end
        SYNTH_STATUS_ADDR: begin
          next_rdata[ST_LOCK_BIT]           = lk.locked;
          next_rdata[ST_MODE_HI:ST_MODE_LO] = mode;
          next_rdata[ST_PLL_ON_BIT]         = pll_on;
        end
        RESET_CTRL_ADDR: next_rdata[FORCE_RST_BIT] = force_rst;
        IRQ_STATUS_ADDR: next_rdata[IRQ_W-1:0]     = irq_status;
        IRQ_MASK_ADDR:   next_rdata[IRQ_W-1:0]     = irq_mask;
        default:         next_rdata                = '0;
      endcase
    end
    next_irq = |(next_irq_status & next_irq_mask);
    unique case (mode)
      PCM_MODE_NORMAL: eff_mult = MULT_BASE + {1'b0, feedback_multiplier_field, 1'b0};  // [RQ11]
      PCM_MODE_ONE:    eff_mult = MULT_ONE;  // [RQ13]
      PCM_MODE_EXT:    eff_mult = MULT_ONE;  // [RQ14]
      default:         eff_mult = MULT_ONE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock pins. The PLL output is only a model: a faster factor gives a
  // shorter toggle period of the core clock, not a true multiplied clock.
  always_comb begin
    next_div_cnt     = div_cnt;
    next_sys_clk     = sys_clk_o;
    next_osc_out     = 1'b0;
    next_reset_out_n = !force_rst;  // [RQ5]
    if (mode != PCM_MODE_EXT && cfg_done) begin
      next_osc_out = !osc_in_i;  // [RQ2]
    end
    if (stop_i) begin
      next_div_cnt = '0;
      next_sys_clk = 1'b0;
    end else if (mode == PCM_MODE_EXT) begin
      next_sys_clk = osc_in_i;  // [RQ16]
    end else if (lk.locked) begin
      if (div_cnt >= SYS_DIV_BASE - eff_mult) begin
        next_div_cnt = '0;
        next_sys_clk = !sys_clk_o;  // [RQ3]
      end else begin
        next_div_cnt = div_cnt + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode             <= PCM_MODE_NORMAL;
      cfg_done         <= 1'b0;
      lock_loss_reset_enable            <= SYNTH_CONTROL_RESET[LOCK_LOSS_RESET_ENABLE_BIT];
      feedback_multiplier_field              <= SYNTH_CONTROL_RESET[MFD_HI:MFD_LO];
      force_rst        <= 1'b0;
      irq_status       <= '0;
      irq_mask         <= '0;
      locked_q         <= 1'b0;
      div_cnt          <= '0;
      sys_clk_o        <= 1'b0;
      osc_out_o        <= 1'b0;
      reset_out_n_o    <= 1'b0;  // [RQ5]
      irq_o            <= 1'b0;
      lock_reset_req_o <= 1'b0;
      rdata_o          <= '0;
    end else begin
      mode             <= next_mode;
      cfg_done         <= next_cfg_done;
      lock_loss_reset_enable            <= next_lock_loss_reset_enable;
      feedback_multiplier_field              <= next_mfd;
      force_rst        <= next_force_rst;
      irq_status       <= next_irq_status;
      irq_mask         <= next_irq_mask;
      locked_q         <= lk.locked;
      div_cnt          <= next_div_cnt;
      sys_clk_o        <= next_sys_clk;
      osc_out_o        <= next_osc_out;
      reset_out_n_o    <= next_reset_out_n;
      irq_o            <= next_irq;
      lock_reset_req_o <= next_req;
      rdata_o          <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ext_no_request: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ10]
    (mode == PCM_MODE_EXT) |=> !lock_reset_req_o)
    else $error("reset request in external clock mode");

  a_loss_resets: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ17]
    (lock_loss_reset_enable && lost_ev && mode != PCM_MODE_EXT) |=> lock_reset_req_o)
    else $error("lock loss did not request reset");

  a_no_enable_quiet: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ7]
    (!lock_loss_reset_enable && !wr_ctrl) |=> !lock_reset_req_o)
    else $error("reset request with enable clear");

  a_enable_unlocked: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ8]
    (wr_ctrl && wdata_i[LOCK_LOSS_RESET_ENABLE_BIT] && !lk.locked && mode != PCM_MODE_EXT)
    |=> lock_reset_req_o)
    else $error("enable set while unlocked gave no reset");

  // Lost event lasts one cycle, the sticky bit follows it
  a_retune_loses: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ12]
    (relock && lk.locked) |=> (lost_ev ##1 irq_status[IRQ_LOST_BIT]))
    else $error("retune did not drop lock");

  a_one_mfd_dead: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ13]
    (mode != PCM_MODE_NORMAL) |-> (!relock && eff_mult == MULT_ONE))
    else $error("multiplier used outside normal mode");

  a_ext_follows: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ16]
    (mode == PCM_MODE_EXT && !stop_i) |=> (sys_clk_o == $past(osc_in_i)))
    else $error("external clock not passed through");

  a_force_pin: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ5]
    force_rst |=> !reset_out_n_o)
    else $error("reset pin high while forced");

  a_user_blocked: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ6]
    (rd_i && !supervisor_i) |=> (rdata_o == '0))
    else $error("user mode read returned data");

  a_mode_frozen: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ4]
    cfg_done |=> $stable(mode))
    else $error("clock mode changed after configuration");

  // Write, one quiet cycle, then the read back
  a_ctrl_readback: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ11]
    wr_ctrl ##1 !wr_ctrl ##1 (rd_ok && addr_i == SYNTH_CONTROL_ADDR)
    |=> (rdata_o[MFD_HI:MFD_LO] == $past(wdata_i[MFD_HI:MFD_LO], 3)))
    else $error("multiplier field not stored");

  a_osc_output_pin_ext_idle: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ2]
    (mode == PCM_MODE_EXT) |=> !osc_out_o)
    else $error("crystal drive active in external mode");
endmodule

//--- common/pcm_pkg.sv
package pcm_pkg;
  localparam int          ADDR_W              = 24;
  localparam int          DATA_W              = 16;
  localparam logic [23:0] SYNTH_CONTROL_ADDR  = 24'h120000;
  localparam logic [23:0] SYNTH_STATUS_ADDR   = 24'h120002;
  localparam logic [23:0] RESET_CTRL_ADDR     = 24'h120004;
  localparam logic [23:0] IRQ_STATUS_ADDR     = 24'h120006;
  localparam logic [23:0] IRQ_MASK_ADDR       = 24'h120008;
  localparam int          LOCK_LOSS_RESET_ENABLE_BIT           = 15;
  localparam int          MFD_HI              = 14;
  localparam int          MFD_LO              = 12;
  localparam int          MFD_W               = 3;
  localparam int          FORCE_RST_BIT       = 7;
  localparam int          ST_LOCK_BIT         = 3;
  localparam int          ST_MODE_HI          = 2;
  localparam int          ST_MODE_LO          = 1;
  localparam int          ST_PLL_ON_BIT       = 0;
  localparam int          IRQ_W               = 2;
  localparam int          IRQ_LOST_BIT        = 0;
  localparam int          IRQ_GAINED_BIT      = 1;
  localparam logic [15:0] SYNTH_CONTROL_RESET = 16'h0000;
  localparam logic [1:0]  MODE_SEL_EXT        = 2'h0;
  localparam logic [1:0]  MODE_SEL_ONE        = 2'h1;
  localparam int          CLK_PERIOD_NS       = 40;
  localparam int          LOCK_TIME_NS        = 2000;
  localparam int          LOCK_CYCLES         = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W               = 12;
  localparam logic [4:0]  MULT_BASE           = 5'h04;
  localparam logic [4:0]  MULT_ONE            = 5'h01;
  localparam logic [4:0]  SYS_DIV_BASE        = 5'h14;
  typedef enum logic [1:0] {
    PCM_MODE_NORMAL,
    PCM_MODE_ONE,
    PCM_MODE_EXT
  } pcm_mode_type;
endpackage

//--- common/pcm_lock_if.sv
interface pcm_lock_if;
  logic pll_on;
  logic relock;
  logic locked;
  modport ctrl (output pll_on, output relock, input locked);
  modport lock (input pll_on, input relock, output locked);
endinterface

//--- verilog/pcm_lock.sv
module pcm_lock
  import pcm_pkg::*;
#(
  parameter int LOCK_CNT = LOCK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  pcm_lock_if.lock  lk
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             locked;
  logic             next_locked;

  assign lk.locked = locked;

  // Any retune or power-down restarts the lock timer
  always_comb begin
    next_cnt    = cnt;
    next_locked = locked;
    if (!lk.pll_on || lk.relock) begin  // [RQ12]
      next_cnt    = '0;
      next_locked = 1'b0;
    end else if (cnt < CNT_W'(LOCK_CNT)) begin
      next_cnt    = cnt + CNT_W'(1);
      next_locked = 1'b0;
    end else begin
      next_locked = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt    <= '0;
      locked <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      locked <= next_locked;
    end
  end

  a_relock_drops: assert property (@(posedge clk_i) disable iff (reset_i) // [RQ12]
    lk.relock |=> !locked) else $error("lock held after retune");
endmodule

//--- verif/pcm_osc_model.sv
module pcm_osc_model #(
  parameter int HALF = 3
) (
  input  wire logic clk_i,
  output logic      osc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  initial begin
    osc_o = 1'h0;
    cnt   = 0;
  end
  // Free running reference; a crystal would look the same here
  always @(posedge clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) osc_o <= ~osc_o;
  end
endmodule

//--- verif/pcm_top_tb.sv
module pcm_top_tb import pcm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, osc, osc_d, stop, stop_off, sup, wr, rd;
  logic        osc_out, sys_clk, rst_n, irq, req;
  logic [1:0]  strap;
  logic [23:0] addr;
  logic [15:0] wdata, rdata;
  logic [31:0] seed;
  int          errors, cmp_count, req_cnt, m_ctrl, m_mode, m_req, m_lock;
  ////////////////////////////////////////////////////////////////////////////////
  // Small lock count keeps each relock to a few cycles
  pcm_top #(.LOCK_CNT(4)) i_dut (
    .clk_i(clk), .reset_i(reset), .osc_in_i(osc), .osc_out_o(osc_out),
    .sys_clk_o(sys_clk), .clock_mode_select_i(strap), .reset_out_n_o(rst_n),
    .stop_i(stop), .stop_pll_off_i(stop_off), .supervisor_i(sup), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
    .lock_reset_req_o(req));
  pcm_osc_model i_osc (.clk_i(clk), .osc_o(osc));
  always #20 clk = ~clk;
  always @(posedge clk) osc_d <= osc;
  always @(posedge clk) if (req === 1'h1) req_cnt++;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] st();
    return {12'h000, m_lock[0], m_mode[1:0], m_mode != 2};
  endfunction
  task automatic chk_reg(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(logic got, logic exp);
    chk_reg({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic chk_cnt();
    chk_reg(req_cnt[15:0], m_req[15:0]);
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Model tracks enable, field and lock; a request is expected per rules below
  task automatic wr16(logic [23:0] a, logic [15:0] d, logic s);
    logic chg;
    @(posedge clk);
    sup   <= s;
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    if (s && a == SYNTH_CONTROL_ADDR) begin
      chg = (m_mode == 0) && (d[14:12] != m_ctrl[14:12]);
      if (m_mode != 2 && d[15] && (!m_lock || chg)) m_req++;
      if (chg) m_lock = 0;
      m_ctrl = d & 16'hF000;
    end
  endtask
  task automatic rd_chk(logic [23:0] a, logic [15:0] exp, logic s = 1'h1);
    @(posedge clk);
    sup  <= s;
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk_reg(rdata, exp);
  endtask
  task automatic rst(logic [1:0] s, int md);
    reset  <= 1'h1;
    strap  <= s;
    m_mode = md;
    m_ctrl = 0;
    m_lock = 0;
    repeat (20) @(posedge clk);
    chk_bit(rst_n, 1'h0);
    reset <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    chk_bit(rst_n, 1'h1);
  endtask
  task automatic wait_lock();
    repeat (20) @(posedge clk);
    if (m_mode != 2) m_lock = 1;
  endtask
  task automatic watch(int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      if (m_mode == 2) chk_bit(sys_clk, osc_d);
      chk_bit(osc_out, (m_mode == 2) ? 1'h0 : ~osc_d);
    end
  endtask
  task automatic new_mfd(logic en);
    logic [2:0] f;
    f = 3'(xs());
    if (f == m_ctrl[14:12]) f ^= 3'h1;
    wr16(SYNTH_CONTROL_ADDR, {en, f, 12'h000}, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 40);
    errors++;
    tally_and_finish();
  end
  initial begin
    {clk, reset, stop, stop_off, sup, wr, rd, addr, wdata} = '0;
    strap = 2'h2;
    seed  = 32'hB378B784;
    rst(2'h2, 0);
    rd_chk(SYNTH_STATUS_ADDR, st());
    rd_chk(SYNTH_CONTROL_ADDR, 16'h0000);
    wait_lock();
    rd_chk(SYNTH_STATUS_ADDR, st());
    watch(12);
    wr16(IRQ_STATUS_ADDR, 16'h0003, 1'h1);
    wr16(IRQ_MASK_ADDR, 16'h0001, 1'h1);
    wr16(SYNTH_CONTROL_ADDR, 16'h8000, 1'h1);
    repeat (8) @(posedge clk);
    chk_cnt();
    for (int i = 0; i < 4; i++) begin
      new_mfd(1'h1);
      rd_chk(SYNTH_CONTROL_ADDR, m_ctrl[15:0]);
      repeat (8) @(posedge clk);
      chk_cnt();
      chk_bit(irq, 1'h1);
      wr16(IRQ_MASK_ADDR, 16'h0000, 1'h1);
      #1;
      chk_bit(irq, 1'h0);
      wr16(IRQ_MASK_ADDR, 16'h0001, 1'h1);
      #1;
      chk_bit(irq, 1'h1);
      wr16(IRQ_STATUS_ADDR, 16'h0001, 1'h1);
      wait_lock();
      chk_bit(irq, 1'h0);
    end
    wr16(SYNTH_CONTROL_ADDR, 16'(xs()), 1'h0);
    rd_chk(SYNTH_CONTROL_ADDR, m_ctrl[15:0]);
    rd_chk(SYNTH_CONTROL_ADDR, 16'h0000, 1'h0);
    wr16(SYNTH_STATUS_ADDR, 16'(xs()), 1'h1);
    rd_chk(SYNTH_STATUS_ADDR, st());
    rd_chk(24'h12000A, 16'h0000);
    wr16(SYNTH_CONTROL_ADDR, m_ctrl[15:0] & 16'h7000, 1'h1);
    new_mfd(1'h0);
    wr16(SYNTH_CONTROL_ADDR, m_ctrl[15:0] | 16'h8000, 1'h1);
    repeat (8) @(posedge clk);
    chk_cnt();
    wait_lock();
    wr16(SYNTH_CONTROL_ADDR, m_ctrl[15:0] & 16'h7000, 1'h1);
    stop     <= 1'h1;
    stop_off <= 1'h1;
    repeat (4) @(posedge clk);
    m_lock = 0;
    chk_bit(sys_clk, 1'h0);
    rd_chk(SYNTH_STATUS_ADDR, 16'h0000);
    stop     <= 1'h0;
    stop_off <= 1'h0;
    wait_lock();
    rd_chk(SYNTH_STATUS_ADDR, st());
    chk_cnt();
    wr16(RESET_CTRL_ADDR, 16'h0080, 1'h1);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(rst_n, 1'h0);
    wr16(RESET_CTRL_ADDR, 16'h0000, 1'h1);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(rst_n, 1'h1);
    rst(2'h1, 1);
    rd_chk(SYNTH_STATUS_ADDR, st());
    wait_lock();
    wr16(SYNTH_CONTROL_ADDR, 16'h8000, 1'h1);
    new_mfd(1'h1);
    repeat (8) @(posedge clk);
    chk_cnt();
    rd_chk(SYNTH_STATUS_ADDR, st());
    rst(2'h0, 2);
    rd_chk(SYNTH_STATUS_ADDR, st());
    wr16(SYNTH_CONTROL_ADDR, 16'hF000, 1'h1);
    repeat (8) @(posedge clk);
    chk_cnt();
    watch(30);
    tally_and_finish();
  end
endmodule
